// >>> common/ssw_pkg.sv
// Contract
// - Disable bit 1 leaves an output protected by overtemperature shutdown only.
// - Disable bit 0: drain-source overvoltage while on switches output off after filter.
// - PWM enable message: top 8 bits command, low 16 bits per-output enables.
// - PWM enable 0 frees output from PWM; 1 puts it under PWM.
// - Power-on, reset pin or reset command clear all PWM enables.
// - Combine bit 0: output is PWM pin AND on/off bit.
// - Combine bit 1: output is PWM pin OR on/off bit.
// - AND/OR combining applies only where PWM enable is 1.
// - Fault word bits read 1 for fault, 0 for none.
// - All latched fault bits clear on chip select rising edge.
// - Fault word bits 15..0 report outputs 15..0.
// - Fault word bits 21..16 always read 0.
// - Bit 22 reports overvoltage; bit 23 set when any fault present.
// - Reset command turns outputs off and restores power-on register values.
// - 24-bit command in, 24-bit fault word out, both MSB first.
// - On/off command: data 1 turns output on, 0 turns it off.
// - Report overtemperature, overcurrent and off-state open load; not on-state open load.
// - Overvoltage turns all off; recovery restores or keeps off per retry bit.
// - Overtemperature shuts only that output; retry or stay off per thermal bit.
// - Overcurrent stays limited until thermal trip, then overtemp handling; flag set.
// - 48-bit frame echoes first 24 bits; last 24 bits execute.
// - Command decoded from bits 23..18, executed at chip select rising edge.
// - Global command: bit 16 overvoltage retry, bit 17 thermal retry, 1 retries.
package ssw_pkg;
  localparam int NUM_OUT = 16;
  localparam int WORD_W = 24;
  localparam int CMD_LSB = 18;
  localparam int CMD_W = 6;
  localparam int OV_RETRY_BIT = 16;
  localparam int TH_RETRY_BIT = 17;
  localparam int RESP_OV_BIT = 22;
  localparam int RESP_ANY_BIT = 23;
  localparam logic [CMD_W-1:0] CMD_ON_OFF = 6'h00;
  localparam logic [CMD_W-1:0] CMD_OL_EN = 6'h01;
  localparam logic [CMD_W-1:0] CMD_GLOBAL = 6'h02;
  localparam logic [CMD_W-1:0] CMD_FAST_SD = 6'h03;
  localparam logic [CMD_W-1:0] CMD_PWM_SEL = 6'h04;
  localparam logic [CMD_W-1:0] CMD_COMBINE = 6'h05;
  localparam logic [CMD_W-1:0] CMD_RESET = 6'h06;
  localparam logic [15:0] RST_ON_OFF = 16'h0000;
  localparam logic [15:0] RST_OL_EN = 16'h0000;
  localparam logic [15:0] RST_FAST_SD = 16'hFFFF;
  localparam logic [15:0] RST_PWM_SEL = 16'h0000;
  localparam logic [15:0] RST_COMBINE = 16'h0000;
  localparam logic RST_OV_RETRY = 1'b0;
  localparam logic RST_TH_RETRY = 1'b0;
  localparam int CLK_MHZ = 250;
  localparam int FILTER_TIME_US = 100;
  localparam int FILTER_CYC = FILTER_TIME_US * CLK_MHZ;
  localparam int CNT_W = 15;
  localparam logic [5:0] BITCNT_MAX = 6'h3F;
  typedef enum logic [0:0] {FR_IDLE, FR_ACTIVE} ssw_frame_t;
endpackage

// >>> hdl/ssw_cmd_fault.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_cmd_fault
  import ssw_pkg::*;
#(
  parameter int FILTER_CYCLES = FILTER_CYC
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Reset pin, active low, asynchronous to sys_clk
  input wire logic reset_pin_n,
  // Serial link
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe_n,
  // PWM pin
  input wire logic pwm_pin,
  // Analog detector levels
  input wire logic battery_supply_ov,
  input wire logic [NUM_OUT-1:0] drain_source_voltage_high,
  input wire logic [NUM_OUT-1:0] overtemp_det,
  input wire logic [NUM_OUT-1:0] overcurrent_det,
  input wire logic [NUM_OUT-1:0] open_load_det,
  // Output stage controls
  output logic [NUM_OUT-1:0] switch_outputs,
  output logic [NUM_OUT-1:0] open_load_current_en
);

  function automatic logic is_cmd(input logic [WORD_W-1:0] w, input logic [CMD_W-1:0] c);
    is_cmd = (w[WORD_W-1:CMD_LSB] == c);
  endfunction

  localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILTER_CYCLES - 1);

  // Two-flop synchronisers; stage one is read only by stage two
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [4+4*NUM_OUT-1:0] ana_s1_r;
  logic [4+4*NUM_OUT-1:0] ana_s2_r;
  logic sclk_prev_r;
  logic cs_prev_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      // Idle pin levels, so no false select or clock edge follows reset
      pin_s1_r <= 4'hA;
      pin_s2_r <= 4'hA;
      sclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end
    else
    begin
      pin_s1_r <= {reset_pin_n, spi_sclk, spi_cs_n, spi_si};
      pin_s2_r <= pin_s1_r;
      sclk_prev_r <= pin_s2_r[2];
      cs_prev_r <= pin_s2_r[1];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ana_s1_r <= '0;
      ana_s2_r <= '0;
    end
    else
    begin
      ana_s1_r <= {2'h0, pwm_pin, battery_supply_ov, drain_source_voltage_high,
                   overtemp_det, overcurrent_det, open_load_det};
      ana_s2_r <= ana_s1_r;
    end
  end

  logic rstpin_n_s;
  logic sclk_s;
  logic cs_s;
  logic si_s;
  logic pwm_s;
  logic ov_s;
  logic [NUM_OUT-1:0] vds_s;
  logic [NUM_OUT-1:0] ot_s;
  logic [NUM_OUT-1:0] oc_s;
  logic [NUM_OUT-1:0] ol_s;
  assign rstpin_n_s = pin_s2_r[3];
  assign sclk_s = pin_s2_r[2];
  assign cs_s = pin_s2_r[1];
  assign si_s = pin_s2_r[0];
  assign pwm_s = ana_s2_r[4*NUM_OUT+1];
  assign ov_s = ana_s2_r[4*NUM_OUT];
  assign vds_s = ana_s2_r[4*NUM_OUT-1:3*NUM_OUT];
  assign ot_s = ana_s2_r[3*NUM_OUT-1:2*NUM_OUT];
  assign oc_s = ana_s2_r[2*NUM_OUT-1:NUM_OUT];
  assign ol_s = ana_s2_r[NUM_OUT-1:0];

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = sclk_s & ~sclk_prev_r;
  assign sclk_fall = ~sclk_s & sclk_prev_r;
  assign cs_fall = ~cs_s & cs_prev_r;
  assign cs_rise = cs_s & ~cs_prev_r;

  // Frame tracking and shifter
  ssw_frame_t frame_r;
  ssw_frame_t frame_nxt;
  logic [WORD_W-1:0] shift_r;
  logic [5:0] bitcnt_r;
  logic [NUM_OUT-1:0] fault_lat_r;
  logic ov_lat_r;
  logic [WORD_W-1:0] resp_word;

  assign resp_word = {(|fault_lat_r) | ov_lat_r, ov_lat_r, 6'h00, fault_lat_r};

  always_comb
  begin
    frame_nxt = frame_r;
    case (frame_r)
      FR_IDLE: if (cs_fall) frame_nxt = FR_ACTIVE;
      FR_ACTIVE: if (cs_rise) frame_nxt = FR_IDLE;
      default: frame_nxt = FR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      frame_r <= FR_IDLE;
    else
      frame_r <= frame_nxt;
  end

  // Shift-through register gives the echo of the first word in long frames
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      shift_r <= '0;
      bitcnt_r <= '0;
    end
    else if (cs_fall)
    begin
      shift_r <= resp_word;
      bitcnt_r <= '0;
    end
    else if (frame_r == FR_ACTIVE && sclk_rise)
    begin
      shift_r <= {shift_r[WORD_W-2:0], si_s};
      if (bitcnt_r != BITCNT_MAX)
        bitcnt_r <= bitcnt_r + 6'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      spi_so <= 1'b0;
      spi_so_oe_n <= 1'b1;
    end
    else
    begin
      spi_so_oe_n <= cs_s;
      if (cs_fall)
        spi_so <= resp_word[WORD_W-1];
      else if (frame_r == FR_ACTIVE && sclk_fall)
        spi_so <= shift_r[WORD_W-1];
    end
  end

  // Command execution; short frames are dropped
  logic exec;
  logic soft_rst;
  logic [WORD_W-1:0] cmd_w;
  assign exec = cs_rise && frame_r == FR_ACTIVE && bitcnt_r >= 6'(WORD_W);
  assign cmd_w = shift_r;
  assign soft_rst = ~rstpin_n_s | (exec & is_cmd(cmd_w, CMD_RESET));

  logic [NUM_OUT-1:0] on_off_r;
  logic [NUM_OUT-1:0] fast_sd_dis_r;
  logic [NUM_OUT-1:0] pwm_sel_r;
  logic [NUM_OUT-1:0] combine_r;
  logic ov_retry_r;
  logic th_retry_r;
  logic ov_prev_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fast_sd_dis_r <= RST_FAST_SD;
      pwm_sel_r <= RST_PWM_SEL;
      combine_r <= RST_COMBINE;
      open_load_current_en <= RST_OL_EN;
      ov_retry_r <= RST_OV_RETRY;
      th_retry_r <= RST_TH_RETRY;
    end
    else if (soft_rst)
    begin
      fast_sd_dis_r <= RST_FAST_SD;
      pwm_sel_r <= RST_PWM_SEL;
      combine_r <= RST_COMBINE;
      open_load_current_en <= RST_OL_EN;
      ov_retry_r <= RST_OV_RETRY;
      th_retry_r <= RST_TH_RETRY;
    end
    else if (exec)
    begin
      if (is_cmd(cmd_w, CMD_FAST_SD))
        fast_sd_dis_r <= cmd_w[NUM_OUT-1:0];
      if (is_cmd(cmd_w, CMD_PWM_SEL))
        pwm_sel_r <= cmd_w[NUM_OUT-1:0];
      if (is_cmd(cmd_w, CMD_COMBINE))
        combine_r <= cmd_w[NUM_OUT-1:0];
      if (is_cmd(cmd_w, CMD_OL_EN))
        open_load_current_en <= cmd_w[NUM_OUT-1:0];
      if (is_cmd(cmd_w, CMD_GLOBAL))
      begin
        ov_retry_r <= cmd_w[OV_RETRY_BIT];
        th_retry_r <= cmd_w[TH_RETRY_BIT];
      end
    end
  end

  // On/off register; overvoltage recovery without retry forces all off
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      on_off_r <= RST_ON_OFF;
      ov_prev_r <= 1'b0;
    end
    else
    begin
      ov_prev_r <= ov_s;
      if (soft_rst)
        on_off_r <= RST_ON_OFF;
      else if (exec && is_cmd(cmd_w, CMD_ON_OFF))
        on_off_r <= cmd_w[NUM_OUT-1:0];
      else if (ov_prev_r && !ov_s && !ov_retry_r)
        on_off_r <= '0;
    end
  end

  // Open load blanking after each command, to skip switching transients
  logic [CNT_W-1:0] blank_cnt_r;
  logic blank_done_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      blank_cnt_r <= '0;
      blank_done_r <= 1'b0;
    end
    else if (cs_rise)
    begin
      blank_cnt_r <= '0;
      blank_done_r <= 1'b0;
    end
    else if (!blank_done_r)
    begin
      blank_cnt_r <= blank_cnt_r + CNT_W'(1);
      blank_done_r <= (blank_cnt_r == FILT_LAST);
    end
  end

  // Per-output protection
  logic [NUM_OUT-1:0] short_off_r;
  logic [NUM_OUT-1:0] ot_off_r;
  logic [NUM_OUT-1:0] drive;
  logic [NUM_OUT-1:0] fault_evt;

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_out
      logic [CNT_W-1:0] sd_cnt_r;
      logic base;

      // Filter runs only while the stage is on and fast shutdown is armed
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          sd_cnt_r <= '0;
        else if (fast_sd_dis_r[g] || !switch_outputs[g] || !vds_s[g])
          sd_cnt_r <= '0;
        else if (sd_cnt_r != FILT_LAST)
          sd_cnt_r <= sd_cnt_r + CNT_W'(1);
      end

      // Stays off until commanded off or reset
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          short_off_r[g] <= 1'b0;
        else if (soft_rst || !on_off_r[g])
          short_off_r[g] <= 1'b0;
        else if (!fast_sd_dis_r[g] && sd_cnt_r == FILT_LAST && vds_s[g])
          short_off_r[g] <= 1'b1;
      end

      // Thermal shutdown of this output only
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          ot_off_r[g] <= 1'b0;
        else if (ot_s[g])
          ot_off_r[g] <= 1'b1;
        else if (soft_rst || th_retry_r || !on_off_r[g])
          ot_off_r[g] <= 1'b0;
      end

      assign base = pwm_sel_r[g] ?
                    (combine_r[g] ? (pwm_s | on_off_r[g]) : (pwm_s & on_off_r[g])) :
                    on_off_r[g];
      assign drive[g] = base & ~ot_off_r[g] & ~short_off_r[g] & ~ov_s;

      // Open load counts only with the output commanded off
      assign fault_evt[g] = ot_s[g] | oc_s[g] | short_off_r[g] |
                            (ol_s[g] & ~on_off_r[g] & open_load_current_en[g] & blank_done_r);
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      switch_outputs <= '0;
    else if (soft_rst)
      switch_outputs <= '0;
    else
      switch_outputs <= drive;
  end

  // Fault latches: a new event wins over the chip select clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fault_lat_r <= '0;
      ov_lat_r <= 1'b0;
    end
    else
    begin
      fault_lat_r <= (cs_rise ? '0 : fault_lat_r) | fault_evt;
      ov_lat_r <= (cs_rise ? 1'b0 : ov_lat_r) | ov_s;
    end
  end

endmodule // ssw_cmd_fault
`default_nettype wire

// >>> tb/ssw_cmd_fault_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_chk
  import ssw_pkg::*;
#(
  parameter int FILTER_CYCLES = FILTER_CYC
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins
  input wire logic reset_pin_n,
  input wire logic spi_cs_n,
  input wire logic spi_so_oe_n,
  input wire logic pwm_pin,
  // Detectors
  input wire logic battery_supply_ov,
  input wire logic [NUM_OUT-1:0] drain_source_voltage_high,
  input wire logic [NUM_OUT-1:0] overtemp_det,
  input wire logic [NUM_OUT-1:0] overcurrent_det,
  // Outputs
  input wire logic [NUM_OUT-1:0] switch_outputs,
  input wire logic [NUM_OUT-1:0] open_load_current_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] quiet_r;
  logic pwm_d_r;
  // Quiet cycles inside a frame; any outside cause restarts the count
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      quiet_r <= 4'h0;
      pwm_d_r <= 1'b0;
    end
    else
    begin
      pwm_d_r <= pwm_pin;
      if (spi_cs_n || !reset_pin_n || battery_supply_ov || (pwm_pin != pwm_d_r) ||
          (|(drain_source_voltage_high | overtemp_det | overcurrent_det)))
        quiet_r <= 4'h0;
      else if (quiet_r != 4'hF)
        quiet_r <= quiet_r + 4'h1;
    end
  end
  sequence s_cs_fall;
    $fell(spi_cs_n);
  endsequence
  sequence s_cs_rise;
    $rose(spi_cs_n);
  endsequence
  property p_oe_on;
    s_cs_fall |-> ##[2:6] !spi_so_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("SO not driven after select");
  property p_oe_off;
    s_cs_rise |-> ##[2:6] spi_so_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("SO still driven");
  property p_oe_frame;
    (!spi_cs_n) [*8] |-> !spi_so_oe_n;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("SO dropped in frame");
  property p_ov_off;
    battery_supply_ov [*4] |-> switch_outputs == 16'h0000;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("Output on in overvoltage");
  property p_ot_off;
    (overtemp_det & $past(overtemp_det) & $past(overtemp_det, 2) & $past(overtemp_det, 3)
      & $past(overtemp_det, 4) & switch_outputs) == 16'h0000;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("Hot output still on");
  property p_rst_pin;
    (!reset_pin_n) [*5] |-> switch_outputs == 16'h0000 && open_load_current_en == 16'h0000;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("Reset pin left outputs");
  property p_hold;
    quiet_r >= 4'h8 |-> $stable(switch_outputs) && $stable(open_load_current_en);
  endproperty
  a_hold: assert property (p_hold) else $error("Outputs moved inside frame");
  property p_after_rst;
    $fell(rst) |-> switch_outputs == 16'h0000 && spi_so_oe_n && open_load_current_en == 16'h0000;
  endproperty
  a_after_rst: assert property (p_after_rst) else $error("Bad state after reset");
endmodule // ssw_chk
bind ssw_cmd_fault ssw_chk #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (.sys_clk, .rst, .reset_pin_n,
  .spi_cs_n, .spi_so_oe_n, .pwm_pin, .battery_supply_ov, .drain_source_voltage_high,
  .overtemp_det, .overcurrent_det, .switch_outputs, .open_load_current_en);
`default_nettype wire

// >>> tb/ssw_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_spi_master
#(
  parameter int GAP = 240
)
(
  // Clock
  input wire logic sys_clk,
  // Link
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_si,
  input wire logic spi_so,
  input wire logic spi_so_oe_n
);
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  // Half of the 64 ns link period
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] r);
    r = 48'h0;
    spi_cs_n = 1'b0;
    half();
    half();
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_si = w[i];
      half();
      spi_sclk = 1'b1;
      // Undriven SO must not read as a lucky match
      r = {r[46:0], spi_so_oe_n ? ~spi_so : spi_so};
      half();
      spi_sclk = 1'b0;
    end
    half();
    spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    repeat (GAP) @(negedge sys_clk);
  endtask
endmodule // ssw_spi_master
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ssw_pkg::*;
;
  logic sys_clk, rst, reset_pin_n, spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe_n, pwm_pin, ov;
  logic [NUM_OUT-1:0] dsv, ot, oc, ol, outs, ol_en, d, p, c;
  logic [47:0] r;
  logic [23:0] k;
  int n_errors = 0;
  int checks = 0;
  // Short filter keeps the run brief; gap scales the 480 us spacing
  ssw_cmd_fault #(.FILTER_CYCLES(50)) uut (.sys_clk, .rst, .reset_pin_n, .spi_sclk, .spi_cs_n,
    .spi_si, .spi_so, .spi_so_oe_n, .pwm_pin, .battery_supply_ov(ov),
    .drain_source_voltage_high(dsv), .overtemp_det(ot), .overcurrent_det(oc),
    .open_load_det(ol), .switch_outputs(outs), .open_load_current_en(ol_en));
  ssw_spi_master #(.GAP(240)) m (.sys_clk, .spi_sclk, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe_n);
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [5:0] code, input logic [17:0] v);
    m.xfer({24'h000000, code, v}, 24, r);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic [23:0] resp(input logic o, input logic [15:0] f);
    return {o | (|f), o, 6'h00, f};
  endfunction
  function automatic logic [23:0] drv(input logic [15:0] on, input logic pin);
    return {8'h00, (~p & on) | (p & ~c & on & {16{pin}}) | (p & c & (on | {16{pin}}))};
  endfunction
  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    {rst, reset_pin_n, pwm_pin, ov} = 4'hC;
    {dsv, ot, oc, ol} = 64'h0;
    {p, c} = 32'h0;
    void'($urandom(32'hFA4A62D5));
    repeat (2) @(posedge sys_clk);
    wt(1);
    rst = 1'b0;
    wt(2);
    k = 24'($urandom());
    d = 16'($urandom());
    m.xfer({k, CMD_ON_OFF, 2'b00, d}, 48, r);
    chk("echo", r[23:0], k);
    chk("fault", r[47:24], 24'h000000);
    chk("outs", {8'h00, outs}, drv(d, 1'b0));
    $display("test echo done");
    for (int i = 0; i < 5; i++)
    begin
      p = (i < 2) ? 16'hFFFF : 16'($urandom());
      c = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom());
      d = 16'($urandom());
      cmd(CMD_PWM_SEL, {2'b00, p});
      cmd(CMD_COMBINE, {2'b00, c});
      cmd(CMD_ON_OFF, {2'b00, d});
      for (int b = 0; b < 2; b++)
      begin
        pwm_pin = b[0];
        wt(10);
        chk("pwm", {8'h00, outs}, drv(d, b[0]));
      end
    end
    $display("test pwm done");
    for (int j = 0; j < 2; j++)
    begin
      pwm_pin = 1'b0;
      cmd(CMD_PWM_SEL, 18'h0FFFF);
      if (j == 0)
        cmd(CMD_RESET, 18'h00000);
      else
      begin
        reset_pin_n = 1'b0;
        wt(10);
        reset_pin_n = 1'b1;
        wt(10);
      end
      {p, c} = 32'h0;
      chk("rst outs", {8'h00, outs}, 24'h000000);
      cmd(CMD_ON_OFF, {2'b00, d});
      chk("rst pwm", {8'h00, outs}, drv(d, 1'b0));
    end
    $display("test reset done");
    k = 24'($urandom());
    ot = k[15:0] | 16'h0001;
    cmd(CMD_ON_OFF, 18'h0FFFF);
    wt(10);
    chk("hot", {8'h00, outs}, {8'h00, ~ot});
    cmd(CMD_ON_OFF, 18'h0FFFF);
    chk("hot word", r[23:0], resp(1'b0, ot));
    ot = 16'h0000;
    cmd(CMD_ON_OFF, 18'h0FFFF);
    cmd(CMD_ON_OFF, 18'h0FFFF);
    chk("cleared", r[23:0], 24'h000000);
    chk("no retry", {8'h00, outs}, {8'h00, ~k[15:0] & 16'hFFFE});
    cmd(CMD_ON_OFF, 18'h00000);
    $display("test thermal done");
    cmd(CMD_OL_EN, 18'h0FFFF);
    chk("ol en", {8'h00, ol_en}, 24'h00FFFF);
    cmd(CMD_ON_OFF, {2'b00, d});
    ol = 16'hFFFF;
    cmd(CMD_ON_OFF, {2'b00, d});
    ol = 16'h0000;
    cmd(CMD_ON_OFF, {2'b00, d});
    chk("open", r[23:0], resp(1'b0, ~d));
    cmd(CMD_ON_OFF, {2'b00, d});
    $display("test open load done");
    for (int j = 0; j < 2; j++)
    begin
      cmd(CMD_GLOBAL, {1'b0, j[0], 16'h0000});
      ov = 1'b1;
      wt(10);
      chk("ov off", {8'h00, outs}, 24'h000000);
      cmd(CMD_ON_OFF, {2'b00, d});
      ov = 1'b0;
      cmd(CMD_ON_OFF, {2'b00, d});
      chk("ov word", r[23:0], resp(1'b1, 16'h0000));
      ov = 1'b1;
      wt(10);
      ov = 1'b0;
      wt(10);
      chk("ov back", {8'h00, outs}, {8'h00, j[0] ? d : 16'h0000});
    end
    $display("test overvoltage done");
    k = 24'($urandom());
    ot = k[15:0] & 16'h00FF;
    oc = k[15:0] | 16'h8000;
    cmd(CMD_GLOBAL, 18'h30000);
    cmd(CMD_ON_OFF, 18'h0FFFF);
    chk("oc hot", {8'h00, outs}, {8'h00, ~ot});
    {ot, oc} = 32'h0;
    cmd(CMD_ON_OFF, 18'h0FFFF);
    chk("oc word", r[23:0], resp(1'b0, k[15:0] | 16'h8000));
    chk("retry", {8'h00, outs}, 24'h00FFFF);
    $display("test retry done");
    k = 24'($urandom());
    cmd(CMD_FAST_SD, {2'b00, k[15:0]});
    cmd(CMD_ON_OFF, 18'h0FFFF);
    dsv = 16'hFFFF;
    wt(80);
    chk("fast sd", {8'h00, outs}, {8'h00, k[15:0]});
    dsv = 16'h0000;
    $display("test short done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
